// >>> src/ebac_ctrl.sv
/*
 External bus area controller: register port, area decode, per-area
 basic cycle sequencer, select merging and pin direction control.
 Assumes pins are resolved outside from the output enables, and that
 straps and all pin inputs come from outside the clock domain.
*/
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module ebac_ctrl
#(
	parameter int DIV = ebac_pkg::BUS_DIV
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic mode_rom_en,
	input wire logic mode_bus8,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire ebac_pkg::ebac_req_t req,
	output logic busy,
	output logic ack,
	output logic [15:0] ack_rdata,
	output logic bus_clk,
	output logic [23:0] addr_out,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic [15:0] data_in,
	output logic rd_n,
	output logic rd_wr,
	output logic cycle_start_n,
	output logic addr_strobe_n,
	output logic addr_hold_n,
	output logic addr_hold_oe,
	output logic upper_write_n,
	output logic upper_write_oe,
	input wire logic upper_write_in,
	output logic lower_write_n,
	output logic [7:0] area_select_n_out,
	output logic [7:0] area_select_n_oe,
	input wire logic [7:0] area_select_n_in,
	input wire logic wait_n
);
	localparam int A = ebac_pkg::AREAS;
	localparam int AW = ebac_pkg::AREA_W;
	localparam int DW = ebac_pkg::DATA_W;
	localparam int BW = ebac_pkg::BYTE_W;
	localparam int HW = ebac_pkg::AREAS / 2 * ebac_pkg::WT_FIELD;
	localparam int SW = DW + 1 + A + 1 + 2;
	localparam logic [AW-1:0] FIRST_LE = 3'h2;

	typedef struct packed {
		ebac_pkg::ebac_state_t st;
		ebac_pkg::ebac_cfg_t cfg;
		ebac_pkg::ebac_req_t rq;
		logic [AW-1:0] area;
		logic [ebac_pkg::WAIT_W-1:0] cnt;
		logic strap_done;
		logic rom_en;
		logic [A-1:0] cs_n;
		logic [31:0] rdata;
		logic busy;
		logic ack;
		logic [DW-1:0] ack_rdata;
		logic [ebac_pkg::ADDR_W-1:0] addr_o;
		logic [DW-1:0] data_o;
		logic data_oe;
		logic rd_n;
		logic rd_wr;
		logic bs_n;
		logic as_n;
		logic ah_n;
		logic ah_oe;
		logic uw_n;
		logic uw_oe;
		logic lw_n;
		logic [A-1:0] sel_out;
		logic [A-1:0] sel_oe;
	} ebac_ctrl_t;
	ebac_ctrl_t s_reg;
	ebac_ctrl_t s_next;

	logic tick;
	logic [SW-1:0] sync_out;
	logic [DW-1:0] data_s;
	logic wait_s;
	logic [A-1:0] sel_in_s;
	logic uw_in_s;
	logic rom_s;
	logic bus8_s;
	logic [2*HW-1:0] wt_all;

	ebac_clkdiv #(.DIV(DIV)) u_div (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.bus_clk(bus_clk),
		.tick(tick)
	);

	ebac_sync #(.W(SW), .INIT('1)) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din({data_in, wait_n, area_select_n_in, upper_write_in,
			mode_rom_en, mode_bus8}),
		.dout(sync_out)
	);
	assign {data_s, wait_s, sel_in_s, uw_in_s, rom_s, bus8_s} = sync_out;
	assign wt_all = {s_reg.cfg.wtb, s_reg.cfg.wta};

	// Prohibited type combinations fall back to the basic interface
	function automatic ebac_pkg::ebac_if_t if_of(
		input ebac_pkg::ebac_cfg_t c, input logic [AW-1:0] a);
		if (c.srm[a] && !c.rom[a] && !c.mpx[a])
			return ebac_pkg::IF_SRAM;
		if (c.rom[a] && !c.srm[a])
			return ebac_pkg::IF_ROM;
		if (c.mpx[a] && !c.srm[a])
			return ebac_pkg::IF_MUX;
		return ebac_pkg::IF_BASIC;
	endfunction: if_of

	function automatic logic is8(
		input ebac_pkg::ebac_cfg_t c, input logic [AW-1:0] a);
		return c.abw[a] && (if_of(c, a) != ebac_pkg::IF_SRAM);
	endfunction: is8

	function automatic logic bus16(input ebac_pkg::ebac_cfg_t c);
		logic any;
		any = 1'b0;
		for (int i = 0; i < A; i++)
			any = any | !is8(c, AW'(i));
		return any;
	endfunction: bus16

	function automatic logic swap_on(
		input ebac_pkg::ebac_cfg_t c, input logic [AW-1:0] a);
		return c.ebo[a] && (a >= FIRST_LE) && !is8(c, a);
	endfunction: swap_on

	always_comb
	begin
		logic three;
		logic [ebac_pkg::WAIT_W-1:0] pw;
		logic [ebac_pkg::EXT_W-1:0] ext;
		logic pin_wait;
		logic fin;
		logic act;
		logic strb;
		logic [AW-1:0] p;
		three = s_reg.cfg.ast[s_reg.area];
		pw = wt_all[s_reg.area*ebac_pkg::WT_FIELD +: ebac_pkg::WAIT_W];
		ext = s_reg.cfg.sec[s_reg.area*ebac_pkg::EXT_W +: ebac_pkg::EXT_W];
		pin_wait = s_reg.cfg.wpe && !wait_s;
		fin = 1'b0;
		act = 1'b0;
		strb = 1'b0;
		p = '0;
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.rdata = '0;

		if (reg_wr)
		begin
			case (reg_addr)
			ebac_pkg::RA_PFC: s_next.cfg.pfc = reg_wdata[A-1:0];
			ebac_pkg::RA_PMAP: s_next.cfg.pmap = reg_wdata[A*AW-1:0];
			ebac_pkg::RA_AST: s_next.cfg.ast = reg_wdata[A-1:0];
			ebac_pkg::RA_WTA: s_next.cfg.wta = reg_wdata[HW-1:0];
			ebac_pkg::RA_WTB: s_next.cfg.wtb = reg_wdata[HW-1:0];
			ebac_pkg::RA_SEC: s_next.cfg.sec = reg_wdata[2*A-1:0];
			ebac_pkg::RA_ABW: s_next.cfg.abw = reg_wdata[A-1:0];
			ebac_pkg::RA_EBO:
				s_next.cfg.ebo = reg_wdata[A-1:0] & ebac_pkg::EBO_MASK;
			ebac_pkg::RA_SRM: s_next.cfg.srm = reg_wdata[A-1:0];
			ebac_pkg::RA_ROM:
				s_next.cfg.rom = reg_wdata[A-1:0] & ebac_pkg::ROM_MASK;
			ebac_pkg::RA_MPX:
				s_next.cfg.mpx = reg_wdata[A-1:0] & ebac_pkg::MPX_MASK;
			ebac_pkg::RA_BCR: s_next.cfg.wpe = reg_wdata[0];
			default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
			ebac_pkg::RA_PFC: s_next.rdata = 32'(s_reg.cfg.pfc);
			ebac_pkg::RA_PMAP: s_next.rdata = 32'(s_reg.cfg.pmap);
			ebac_pkg::RA_AST: s_next.rdata = 32'(s_reg.cfg.ast);
			ebac_pkg::RA_WTA: s_next.rdata = 32'(s_reg.cfg.wta);
			ebac_pkg::RA_WTB: s_next.rdata = 32'(s_reg.cfg.wtb);
			ebac_pkg::RA_SEC: s_next.rdata = 32'(s_reg.cfg.sec);
			ebac_pkg::RA_ABW: s_next.rdata = 32'(s_reg.cfg.abw);
			ebac_pkg::RA_EBO: s_next.rdata = 32'(s_reg.cfg.ebo);
			ebac_pkg::RA_SRM: s_next.rdata = 32'(s_reg.cfg.srm);
			ebac_pkg::RA_ROM: s_next.rdata = 32'(s_reg.cfg.rom);
			ebac_pkg::RA_MPX: s_next.rdata = 32'(s_reg.cfg.mpx);
			ebac_pkg::RA_BCR: s_next.rdata = 32'(s_reg.cfg.wpe);
			ebac_pkg::RA_STAT: s_next.rdata = 32'({uw_in_s, sel_in_s,
				s_reg.strap_done, s_reg.area, bus16(s_reg.cfg),
				s_reg.busy});
			default: s_next.rdata = '0;
			endcase
		end

		// Straps are taken once, after the synchroniser has settled
		if (tick && !s_reg.strap_done)
		begin
			s_next.strap_done = 1'b1;
			s_next.rom_en = rom_s;
			s_next.cfg.pfc = rom_s ? '0 : ebac_pkg::PFC_NOROM;
			s_next.cfg.abw = bus8_s ? ebac_pkg::ABW_ALL8 : '0;
		end

		case (s_reg.st)
		ebac_pkg::S_IDLE:
		begin
			if (req_valid && s_reg.strap_done)
			begin
				s_next.rq = req;
				s_next.area = req.addr[ebac_pkg::ADDR_W-1 -: AW];
				if (req.internal)
					s_next.ack = 1'b1;
				else
				begin
					s_next.st = ebac_pkg::S_START;
					s_next.busy = 1'b1;
				end
			end
		end
		ebac_pkg::S_START:
			if (tick)
				s_next.st = (ext != '0) ? ebac_pkg::S_TH : ebac_pkg::S_T1;
		ebac_pkg::S_TH:
			if (tick)
				s_next.st = ebac_pkg::S_T1;
		ebac_pkg::S_T1:
			if (tick)
				s_next.st = ebac_pkg::S_T2;
		ebac_pkg::S_T2:
		begin
			if (tick && !three)
				fin = 1'b1;
			else if (tick && pw != '0)
			begin
				s_next.st = ebac_pkg::S_TPW;
				s_next.cnt = pw - 1'b1;
			end
			else if (tick)
				s_next.st = pin_wait ? ebac_pkg::S_TW : ebac_pkg::S_T3;
		end
		ebac_pkg::S_TPW:
		begin
			if (tick && s_reg.cnt != '0)
				s_next.cnt = s_reg.cnt - 1'b1;
			else if (tick)
				s_next.st = pin_wait ? ebac_pkg::S_TW : ebac_pkg::S_T3;
		end
		ebac_pkg::S_TW:
			if (tick && !pin_wait)
				s_next.st = ebac_pkg::S_T3;
		ebac_pkg::S_T3:
			if (tick)
				fin = 1'b1;
		ebac_pkg::S_TT:
		begin
			if (tick)
			begin
				s_next.st = ebac_pkg::S_IDLE;
				s_next.busy = 1'b0;
				s_next.ack = 1'b1;
			end
		end
		default:
			s_next.st = ebac_pkg::S_IDLE;
		endcase

		if (fin)
		begin
			if (is8(s_reg.cfg, s_reg.area))
				s_next.ack_rdata = {{BW{1'b0}}, data_s[BW-1:0]};
			else if (swap_on(s_reg.cfg, s_reg.area) && s_reg.rq.word)
				s_next.ack_rdata = ebac_pkg::ebac_swap(data_s);
			else
				s_next.ack_rdata = data_s;
			if (ext == ebac_pkg::EXT_TWO)
				s_next.st = ebac_pkg::S_TT;
			else
			begin
				s_next.st = ebac_pkg::S_IDLE;
				s_next.busy = 1'b0;
				s_next.ack = 1'b1;
			end
		end

		// Pin values follow the next state so they leave flops directly
		act = s_next.st inside {ebac_pkg::S_TH, ebac_pkg::S_T1,
			ebac_pkg::S_T2, ebac_pkg::S_TPW, ebac_pkg::S_TW,
			ebac_pkg::S_T3, ebac_pkg::S_TT};
		strb = s_next.st inside {ebac_pkg::S_T1, ebac_pkg::S_T2,
			ebac_pkg::S_TPW, ebac_pkg::S_TW, ebac_pkg::S_T3};
		s_next.cs_n = '1;
		if (act)
			s_next.cs_n[s_next.area] = 1'b0;
		s_next.sel_out = '1;
		s_next.sel_oe = '0;
		for (int i = 0; i < A; i++)
		begin
			p = s_next.cfg.pmap[i*AW +: AW];
			if (s_next.cfg.pfc[i])
			begin
				s_next.sel_oe[p] = 1'b1;
				if (!s_next.cs_n[i])
					s_next.sel_out[p] = 1'b0;
			end
		end
		s_next.addr_o = act ? s_next.rq.addr : s_reg.addr_o;
		s_next.rd_wr = !(act && s_next.rq.write);
		s_next.rd_n = !(strb && !s_next.rq.write);
		s_next.lw_n = !(strb && s_next.rq.write);
		s_next.uw_n = !(strb && s_next.rq.write && s_next.rq.word
			&& !is8(s_next.cfg, s_next.area));
		s_next.uw_oe = bus16(s_next.cfg);
		s_next.data_oe = strb && s_next.rq.write;
		if (swap_on(s_next.cfg, s_next.area) && s_next.rq.word)
			s_next.data_o = ebac_pkg::ebac_swap(s_next.rq.wdata);
		else
			s_next.data_o = s_next.rq.wdata;
		s_next.bs_n = (s_next.st != ebac_pkg::S_T1);
		if (if_of(s_next.cfg, s_next.area) == ebac_pkg::IF_MUX)
		begin
			s_next.as_n = 1'b1;
			s_next.ah_n = (s_next.st != ebac_pkg::S_T1);
		end
		else
		begin
			s_next.as_n = !strb;
			s_next.ah_n = 1'b1;
		end
		s_next.ah_oe = (s_next.cfg.mpx != '0);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_reg <= '0;
			s_reg.st <= ebac_pkg::S_IDLE;
			s_reg.cfg.pmap <= ebac_pkg::PMAP_RST;
			s_reg.cfg.ast <= ebac_pkg::AST_RST;
			s_reg.cfg.wta <= ebac_pkg::WT_RST;
			s_reg.cfg.wtb <= ebac_pkg::WT_RST;
			s_reg.cs_n <= '1;
			s_reg.sel_out <= '1;
			s_reg.rd_n <= 1'b1;
			s_reg.rd_wr <= 1'b1;
			s_reg.bs_n <= 1'b1;
			s_reg.as_n <= 1'b1;
			s_reg.ah_n <= 1'b1;
			s_reg.uw_n <= 1'b1;
			s_reg.lw_n <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign reg_rdata = s_reg.rdata;
	assign busy = s_reg.busy;
	assign ack = s_reg.ack;
	assign ack_rdata = s_reg.ack_rdata;
	assign addr_out = s_reg.addr_o;
	assign data_out = s_reg.data_o;
	assign data_oe = s_reg.data_oe;
	assign rd_n = s_reg.rd_n;
	assign rd_wr = s_reg.rd_wr;
	assign cycle_start_n = s_reg.bs_n;
	assign addr_strobe_n = s_reg.as_n;
	assign addr_hold_n = s_reg.ah_n;
	assign addr_hold_oe = s_reg.ah_oe;
	assign upper_write_n = s_reg.uw_n;
	assign upper_write_oe = s_reg.uw_oe;
	assign lower_write_n = s_reg.lw_n;
	assign area_select_n_out = s_reg.sel_out;
	assign area_select_n_oe = s_reg.sel_oe;

	area_select_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_reg.st == ebac_pkg::S_T1 |-> s_reg.cs_n == ~(8'h01 << s_reg.area))
		else $error("area select does not match decoded area");

	merged_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!s_reg.cs_n[s_reg.area] && s_reg.cfg.pfc[s_reg.area]) |->
		!area_select_n_out[s_reg.cfg.pmap[s_reg.area*AW +: AW]])
		else $error("merged select pin not low during access");

	strap_dir_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(s_reg.strap_done) |-> ##1
		area_select_n_oe == (s_reg.rom_en ? 8'h00 : ebac_pkg::PFC_NOROM))
		else $error("select pin direction wrong after reset");

	width_strap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(s_reg.strap_done) |->
		s_reg.cfg.abw == ($past(bus8_s) ? ebac_pkg::ABW_ALL8 : 8'h00))
		else $error("width reset value not from mode");

	two_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(s_reg.st == ebac_pkg::S_T2 && tick && !s_reg.cfg.ast[s_reg.area])
		|=> (s_reg.st == ebac_pkg::S_IDLE || s_reg.st == ebac_pkg::S_TT))
		else $error("2-state access inserted a wait");

	write_swap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(data_oe && s_reg.rq.word && swap_on(s_reg.cfg, s_reg.area)) |->
		data_out == ebac_pkg::ebac_swap(s_reg.rq.wdata))
		else $error("little-endian write not swapped");

	upper_unused_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!bus16(s_reg.cfg) |-> !upper_write_oe && upper_write_n)
		else $error("upper write strobe driven in 8-bit bus mode");

	internal_fixed_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(s_reg.st == ebac_pkg::S_IDLE && s_reg.strap_done && req_valid
		&& req.internal) |=> ack && !busy && cycle_start_n)
		else $error("internal access did not finish in one cycle");
endmodule: ebac_ctrl

// >>> src/ebac_pkg.sv
/*
 Constants, types and carriers of the external bus area controller.
 Assumes one 20 MHz system clock and an active-low asynchronous reset.
*/
// Overview of operation
// - Split the 16-Mbyte space into eight areas; apply that area's settings.
// - Drive each area's active-low select low while its access runs.
// - ROM-less extended mode: area 0 select outputs after reset, others inputs.
// - Extended mode with ROM: all eight selects are inputs after reset.
// - Selects routed to one pin are merged; pin low if any area accessed.
// - Settings are per area; internal accesses keep fixed width and timing.
// - Four interface types per area; every area resets to basic.
// - Burst ROM only in areas 0 and 1, multiplexed only in 3 to 7.
// - Each area is an 8-bit or 16-bit access space.
// - Byte-control SRAM always 16-bit; multiplexed areas either width.
// - 8-bit bus mode only if all areas 8-bit, else 16-bit mode.
// - Width reset value comes from the operating mode.
// - Areas 2 to 7 can swap bytes when set little endian.
// - Byte order resets to big endian for every area.
// - Basic areas use 2-state or 3-state access per setting.
// - 2-state never waits; 3-state adds 0 to 7 programmed or pin waits.
// - Select and address extended by 0, 1 or 2 cycles.
// - Unused control pins act as plain port inputs.
// - Upper write strobe serves 16-bit accesses only.
package ebac_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int AREAS = 8;
	localparam int AREA_W = 3;
	localparam int WAIT_W = 3;
	localparam int WT_FIELD = 4;
	localparam int EXT_W = 2;
	localparam int REG_W = 32;
	localparam int RA_W = 4;
	localparam int SYS_CLK_NS = 50;
	localparam int BUS_CLK_NS = 400;
	localparam int BUS_DIV = BUS_CLK_NS / SYS_CLK_NS;
	localparam logic [3:0] RA_PFC = 4'h0;
	localparam logic [3:0] RA_PMAP = 4'h1;
	localparam logic [3:0] RA_AST = 4'h2;
	localparam logic [3:0] RA_WTA = 4'h3;
	localparam logic [3:0] RA_WTB = 4'h4;
	localparam logic [3:0] RA_SEC = 4'h5;
	localparam logic [3:0] RA_ABW = 4'h6;
	localparam logic [3:0] RA_EBO = 4'h7;
	localparam logic [3:0] RA_SRM = 4'h8;
	localparam logic [3:0] RA_ROM = 4'h9;
	localparam logic [3:0] RA_MPX = 4'hA;
	localparam logic [3:0] RA_BCR = 4'hB;
	localparam logic [3:0] RA_STAT = 4'hC;
	localparam logic [7:0] PFC_NOROM = 8'h01;
	localparam logic [23:0] PMAP_RST = 24'hFAC688;
	localparam logic [7:0] AST_RST = 8'hFF;
	localparam logic [15:0] WT_RST = 16'h7777;
	localparam logic [7:0] ABW_ALL8 = 8'hFF;
	localparam logic [7:0] ROM_MASK = 8'h03;
	localparam logic [7:0] MPX_MASK = 8'hF8;
	localparam logic [7:0] EBO_MASK = 8'hFC;
	localparam logic [1:0] EXT_TWO = 2'h2;

	typedef enum logic [3:0] {S_IDLE, S_START, S_TH, S_T1, S_T2, S_TPW,
		S_TW, S_T3, S_TT} ebac_state_t;
	typedef enum logic [1:0] {IF_BASIC, IF_SRAM, IF_ROM, IF_MUX} ebac_if_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
		logic word;
		logic internal;
	} ebac_req_t;

	typedef struct packed {
		logic [AREAS-1:0] pfc;
		logic [AREAS*AREA_W-1:0] pmap;
		logic [AREAS-1:0] ast;
		logic [AREAS/2*WT_FIELD-1:0] wta;
		logic [AREAS/2*WT_FIELD-1:0] wtb;
		logic [AREAS*EXT_W-1:0] sec;
		logic [AREAS-1:0] abw;
		logic [AREAS-1:0] ebo;
		logic [AREAS-1:0] srm;
		logic [AREAS-1:0] rom;
		logic [AREAS-1:0] mpx;
		logic wpe;
	} ebac_cfg_t;

	function automatic logic [DATA_W-1:0] ebac_swap(input logic [DATA_W-1:0] d);
		return {d[BYTE_W-1:0], d[DATA_W-1:BYTE_W]};
	endfunction: ebac_swap
endpackage: ebac_pkg

// >>> src/ebac_sync.sv
/*
 Two-flop synchroniser for a vector of pin inputs.
 Assumes each bit is a level that may change at any time.
*/
`timescale 1ns/1ps
module ebac_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ebac_sync_t;
	ebac_sync_t s_reg;
	ebac_sync_t s_next;

	always_comb
	begin
		s_next.s1 = din;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			s_reg <= {INIT, INIT};
		else
			s_reg <= s_next;
	end

	assign dout = s_reg.s2;
endmodule: ebac_sync

// >>> src/ebac_clkdiv.sv
/*
 Divider for the external bus clock and its one-cycle tick.
 Assumes DIV is even and at least two.
*/
`timescale 1ns/1ps
module ebac_clkdiv
#(
	parameter int DIV = ebac_pkg::BUS_DIV
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	output logic bus_clk,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic clk;
		logic tick;
	} ebac_div_t;
	ebac_div_t d_reg;
	ebac_div_t d_next;

	// Tick marks the rising edge of the driven bus clock
	always_comb
	begin
		d_next = d_reg;
		d_next.cnt = (d_reg.cnt == LAST) ? '0 : d_reg.cnt + 1'b1;
		d_next.clk = (d_next.cnt < HALF);
		d_next.tick = (d_reg.cnt == LAST);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			d_reg <= '0;
		else
			d_reg <= d_next;
	end

	assign bus_clk = d_reg.clk;
	assign tick = d_reg.tick;
endmodule: ebac_clkdiv

// >>> dv/ebac_mem_model.sv
/*
 Behavioural external memory chip on the basic bus of the area controller.
 Assumes it sees the resolved strobe pins and the divided bus clock.
*/
`timescale 1ns/1ps
module ebac_mem_model
(
	input wire logic bus_clk,
	input wire logic [23:0] addr_out,
	input wire logic [15:0] data_out,
	input wire logic rd_n,
	input wire logic cycle_start_n,
	input wire logic upper_write_n,
	input wire logic lower_write_n,
	input wire logic [7:0] hold_len,
	output logic [15:0] data_in,
	output logic wait_n
);
	logic [15:0] mem [0:255];
	logic [7:0] hold_cnt;

	initial
	begin
		data_in = 16'h0000;
		hold_cnt = 8'h00;
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
	end

	// Bytes are taken mid-state, away from the pin update
	always @(negedge bus_clk)
	begin
		if (lower_write_n === 1'b0)
			mem[addr_out[7:0]][7:0] <= data_out[7:0];
		if (upper_write_n === 1'b0)
			mem[addr_out[7:0]][15:8] <= data_out[15:8];
		if (rd_n === 1'b0)
			data_in <= mem[addr_out[7:0]];
		else
			data_in <= ~data_in;
	end

	// Stretch request held for hold_len bus clocks from cycle start
	always @(posedge bus_clk)
	begin
		if (cycle_start_n === 1'b0)
			hold_cnt <= hold_len;
		else if (hold_cnt != 8'h00)
			hold_cnt <= hold_cnt - 8'h01;
	end
	assign wait_n = (hold_cnt == 8'h00);
endmodule: ebac_mem_model

// >>> dv/test_external_bus_area_control.sv
/*
 Self-checking bench of the external bus area controller.
 Assumes the memory model on the pins and pull-ups on the select pins.
*/
`timescale 1ns/1ps
module test_external_bus_area_control;
	localparam int DIV = 8;
	logic clk_sys, rstn, mode_rom_en, mode_bus8, reg_wr, reg_rd, req_valid;
	logic busy, ack, bus_clk, data_oe, rd_n, rd_wr, cycle_start_n, three;
	logic addr_strobe_n, addr_hold_n, addr_hold_oe, upper_write_n;
	logic upper_write_oe, lower_write_n, wait_n, upper_seen;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [15:0] ack_rdata, data_out, data_in, wseen, rdat, d;
	logic [23:0] addr_out, a;
	logic [7:0] area_select_n_out, area_select_n_oe, cs_pin, hold_len;
	logic [7:0] abw, ebo;
	ebac_pkg::ebac_req_t req;
	integer seed, fails, checks, cs_cnt, stray, watch, cyc, w, e;

	assign cs_pin = area_select_n_out | ~area_select_n_oe;

	ebac_ctrl #(.DIV(DIV)) u_ebac_ctrl (.clk_sys(clk_sys), .rstn(rstn),
		.mode_rom_en(mode_rom_en), .mode_bus8(mode_bus8),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
		.req(req), .busy(busy), .ack(ack), .ack_rdata(ack_rdata),
		.bus_clk(bus_clk), .addr_out(addr_out), .data_out(data_out),
		.data_oe(data_oe), .data_in(data_in), .rd_n(rd_n), .rd_wr(rd_wr),
		.cycle_start_n(cycle_start_n), .addr_strobe_n(addr_strobe_n),
		.addr_hold_n(addr_hold_n), .addr_hold_oe(addr_hold_oe),
		.upper_write_n(upper_write_n), .upper_write_oe(upper_write_oe),
		.upper_write_in(1'b1), .lower_write_n(lower_write_n),
		.area_select_n_out(area_select_n_out),
		.area_select_n_oe(area_select_n_oe), .area_select_n_in(cs_pin),
		.wait_n(wait_n));

	ebac_mem_model u_ebac_mem_model (.bus_clk(bus_clk),
		.addr_out(addr_out), .data_out(data_out), .rd_n(rd_n),
		.cycle_start_n(cycle_start_n), .upper_write_n(upper_write_n),
		.lower_write_n(lower_write_n), .hold_len(hold_len),
		.data_in(data_in), .wait_n(wait_n));

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Select pin activity and write strobes of the running access
	always @(negedge clk_sys)
	begin
		for (int p = 0; p < 8; p++)
			if (cs_pin[p] === 1'b0)
			begin
				if (p == watch)
					cs_cnt++;
				else
					stray++;
			end
		if (lower_write_n === 1'b0)
			wseen = data_out;
		if (upper_write_n === 1'b0 && upper_write_oe === 1'b1)
			upper_seen = 1'b1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask: check

	task automatic test_done;
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask: test_done

	task automatic do_reset(input logic rom, input logic bus8);
		@(posedge clk_sys);
		rstn <= 1'b0;
		mode_rom_en <= rom;
		mode_bus8 <= bus8;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (20) @(posedge clk_sys);
	endtask: do_reset

	task automatic reg_write(input logic [3:0] ra, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= ra;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask: reg_write

	task automatic reg_expect(input logic [3:0] ra, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= ra;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		check(reg_rdata, v);
	endtask: reg_expect

	// One access; len below zero skips the select length compare
	task automatic ext_op(input integer pin, input logic [23:0] ad,
		input logic [15:0] wd, input logic wr, input logic in,
		input integer len);
		@(posedge clk_sys);
		watch = pin;
		cs_cnt = 0;
		stray = 0;
		upper_seen = 1'b0;
		wseen = 16'hXXXX;
		req_valid <= 1'b1;
		req <= '{ad, wd, wr, 1'b1, in};
		@(posedge clk_sys);
		req_valid <= 1'b0;
		cyc = 0;
		do
		begin
			@(negedge clk_sys);
			cyc++;
			if (cyc == 1)
				check(busy, !in);
		end
		while (ack !== 1'b1 && cyc < 3000);
		rdat = ack_rdata;
		check(cyc < 3000, 1'b1);
		if (len >= 0)
			check(cs_cnt, len);
		check(stray, 0);
	endtask: ext_op

	function automatic logic [15:0] pin_data(input logic [2:0] ar,
		input logic [15:0] v);
		if (abw[ar])
			return {8'h00, v[7:0]};
		if (ebo[ar] && ar >= 3'h2)
			return {v[7:0], v[15:8]};
		return v;
	endfunction: pin_data

	initial
	begin
		#1000000;
		fails++;
		test_done;
	end

	initial
	begin
		seed = 41;
		fails = 0;
		checks = 0;
		watch = 0;
		rstn = 1'b0;
		mode_rom_en = 1'b0;
		mode_bus8 = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		req_valid = 1'b0;
		req = '0;
		hold_len = 8'h00;
		do_reset(1'b0, 1'b1);
		check(area_select_n_oe, 8'h01);
		check(upper_write_oe, 1'b0);
		reg_expect(ebac_pkg::RA_ABW, 32'hFF);
		reg_expect(ebac_pkg::RA_EBO, 32'h0);
		reg_expect(ebac_pkg::RA_AST, 32'hFF);
		reg_expect(ebac_pkg::RA_WTA, 32'h7777);
		do_reset(1'b1, 1'b0);
		check(area_select_n_oe, 8'h00);
		check(upper_write_oe, 1'b1);
		reg_expect(ebac_pkg::RA_ABW, 32'h0);
		for (int r = 8; r <= 10; r++)
			reg_expect(4'(r), 32'h0);
		reg_write(ebac_pkg::RA_ROM, 32'hFF);
		reg_expect(ebac_pkg::RA_ROM, 32'h03);
		reg_write(ebac_pkg::RA_MPX, 32'hFF);
		reg_expect(ebac_pkg::RA_MPX, 32'hF8);
		check(addr_hold_oe, 1'b1);
		reg_write(ebac_pkg::RA_ROM, 32'h0);
		reg_write(ebac_pkg::RA_MPX, 32'h0);
		reg_expect(4'hD, 32'h0);
		check(addr_hold_oe, 1'b0);
		reg_write(ebac_pkg::RA_PFC, 32'hFF);
		for (int i = 0; i < 24; i++)
		begin
			w = $unsigned($random(seed)) % 8;
			e = $unsigned($random(seed)) % 3;
			three = $random(seed);
			abw = $random(seed);
			ebo = $random(seed);
			ebo[1:0] = 2'h0;
			d = $random(seed);
			a = $random(seed);
			a[0] = 1'b0;
			reg_write(ebac_pkg::RA_AST, {24'h0, {8{three}}});
			reg_write(ebac_pkg::RA_WTA, {16'h0, {4{4'(w)}}});
			reg_write(ebac_pkg::RA_WTB, {16'h0, {4{4'(w)}}});
			reg_write(ebac_pkg::RA_SEC, {16'h0, {8{2'(e)}}});
			reg_write(ebac_pkg::RA_ABW, {24'h0, abw});
			reg_write(ebac_pkg::RA_EBO, {24'h0, ebo});
			check(upper_write_oe, abw != 8'hFF);
			ext_op(a[23:21], a, d, 1'b1, 1'b0,
				DIV * ((three ? 3 + w : 2) + e));
			check(wseen & (abw[a[23:21]] ? 16'h00FF : 16'hFFFF),
				pin_data(a[23:21], d));
			check(upper_seen, !abw[a[23:21]]);
			check(addr_out, a);
			ext_op(a[23:21], a, 16'h0, 1'b0, 1'b0,
				DIV * ((three ? 3 + w : 2) + e));
			check(rdat, abw[a[23:21]] ? {8'h00, d[7:0]} : d);
		end
		reg_write(ebac_pkg::RA_AST, 32'h0);
		reg_write(ebac_pkg::RA_SEC, 32'h0);
		reg_write(ebac_pkg::RA_ABW, 32'h0);
		reg_write(ebac_pkg::RA_PMAP,
			({8'h0, ebac_pkg::PMAP_RST} & ~32'h1C0000) | 32'h140000);
		reg_write(ebac_pkg::RA_PFC, 32'h60);
		ext_op(5, 24'hC00010, 16'h1234, 1'b1, 1'b0, 2 * DIV);
		ext_op(5, 24'hA00010, 16'h4321, 1'b1, 1'b0, 2 * DIV);
		ext_op(2, 24'h400010, 16'h5A5A, 1'b1, 1'b0, 0);
		reg_write(ebac_pkg::RA_PFC, 32'hFF);
		reg_write(ebac_pkg::RA_BCR, 32'h1);
		hold_len <= 8'hC8;
		ext_op(2, 24'h400020, 16'h0, 1'b0, 1'b0, 2 * DIV);
		reg_write(ebac_pkg::RA_AST, 32'hFF);
		reg_write(ebac_pkg::RA_WTA, 32'h0);
		reg_write(ebac_pkg::RA_WTB, 32'h0);
		hold_len <= 8'h02;
		ext_op(2, 24'h400020, 16'h0, 1'b0, 1'b0, -1);
		check(cs_cnt > 3 * DIV && cs_cnt <= 7 * DIV, 1'b1);
		hold_len <= 8'h00;
		ext_op(0, 24'h000040, 16'h0, 1'b0, 1'b1, 0);
		check(cyc, 1);
		test_done;
	end
endmodule: test_external_bus_area_control
